// ---- sim/csi_checker.sv ----
// Purpose: port assertions for the step-up and insert edit block
// Assumes: timing pulses one cycle wide, one clock domain
// Notes: bound into every csi_edit instance
`timescale 1ns/10ps
`default_nettype none
module csi_checker (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PHASE2_PULSE,
   input wire logic CHAR_TIME_PULSE,
   input wire logic LINE_END_PULSE,
   input wire logic CURSOR_LOCATED,
   input wire logic CE_SER_DATA,
   input wire logic DL_SER_DATA,
   input wire logic LOOP_BYPASS,
   input wire logic CURSOR_ERASE,
   input wire logic CURSOR_WRITE,
   input wire logic COUNT88_CLEAR,
   input wire logic STEP_UP_BUSY,
   input wire logic INSERT_BUSY
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_su_loc;
      $rose(CURSOR_LOCATED) && STEP_UP_BUSY;
   endsequence
   sequence s_ins_loc;
      $rose(CURSOR_LOCATED) && INSERT_BUSY && !LOOP_BYPASS;
   endsequence
   a_erase_at_locate: assert property (s_su_loc |=> CURSOR_ERASE)
      else $error("cursor not erased after locate");
   a_write_after_tick: assert property (CURSOR_WRITE |-> $past(CHAR_TIME_PULSE, 2))
      else $error("cursor write not two cycles after tick");
   a_bypass_at_locate: assert property (s_ins_loc |=> LOOP_BYPASS)
      else $error("insert flag not set at locate");
   a_bypass_end_eol: assert property ($fell(LOOP_BYPASS) |-> $past(LINE_END_PULSE))
      else $error("insert flag cleared without line end");
   a_bypass_only_ins: assert property (LOOP_BYPASS |-> INSERT_BUSY && !STEP_UP_BUSY)
      else $error("loop bypass outside insert");
   a_normal_loop: assert property (!LOOP_BYPASS && $past(LOOP_BYPASS) == 1'b0
      && $past(PHASE2_PULSE) && $past(RST_N)
      |-> DL_SER_DATA == $past(CE_SER_DATA))
      else $error("normal loop path broken");
   a_idle_clear: assert property (!STEP_UP_BUSY && !INSERT_BUSY
      && $past(STEP_UP_BUSY) == 1'b0 && $past(INSERT_BUSY) == 1'b0
      |-> COUNT88_CLEAR)
      else $error("counter not held clear when idle");
   a_reset_idle: assert property ($rose(RST_N) |-> !STEP_UP_BUSY && !INSERT_BUSY
      && DL_SER_DATA && COUNT88_CLEAR && !LOOP_BYPASS)
      else $error("not idle after reset");
endmodule // csi_checker
bind csi_edit csi_checker u_csi_checker (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .PHASE2_PULSE(PHASE2_PULSE), .CHAR_TIME_PULSE(CHAR_TIME_PULSE),
   .LINE_END_PULSE(LINE_END_PULSE), .CURSOR_LOCATED(CURSOR_LOCATED),
   .CE_SER_DATA(CE_SER_DATA), .DL_SER_DATA(DL_SER_DATA),
   .LOOP_BYPASS(LOOP_BYPASS), .CURSOR_ERASE(CURSOR_ERASE),
   .CURSOR_WRITE(CURSOR_WRITE), .COUNT88_CLEAR(COUNT88_CLEAR),
   .STEP_UP_BUSY(STEP_UP_BUSY), .INSERT_BUSY(INSERT_BUSY));
`default_nettype wire

// ---- sim/csi_loop_model.sv ----
// Purpose: timing and cursor of the recirculating refresh loop
// Assumes: 16 clocks per character, loop bit every other clock
// Notes: no retrace slots; frame is lines times 88 characters
`timescale 1ns/10ps
`default_nettype none
module csi_loop_model #(
   parameter int LINES = 14,
   parameter int CUR0 = 264
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cur_erase,
   input wire logic cur_write,
   output logic char_pulse,
   output logic phase_b,
   output logic ph2,
   output logic line_start,
   output logic frame_start,
   output logic line_end,
   output logic vdrive,
   output logic first_slot,
   output logic cur_loc
);
   localparam int N = LINES * 88;
   logic [3:0] bit_q;
   int slot_q;
   int cur_q;
   logic cv_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q <= 4'h0;
         slot_q <= 0;
      end else begin
         bit_q <= bit_q + 4'h1;
         if (bit_q == 4'hF) slot_q <= (slot_q == N - 1) ? 0 : slot_q + 1;
      end
   end
   // cursor leaves the loop on erase, back one slot on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= CUR0;
         cv_q <= 1'b1;
      end else if (cur_erase) begin
         cv_q <= 1'b0;
      end else if (cur_write) begin
         cv_q <= 1'b1;
         cur_q <= (slot_q == N - 1) ? 0 : slot_q + 1;
      end
   end
   assign char_pulse = (bit_q == 4'h0);
   assign phase_b = (bit_q == 4'h4);
   assign ph2 = bit_q[0];
   assign first_slot = (slot_q % 88 == 0);
   assign line_start = char_pulse && first_slot;
   assign frame_start = char_pulse && slot_q == 0;
   assign line_end = char_pulse && (slot_q % 88 == 87);
   assign vdrive = (slot_q >= N - 88);
   assign cur_loc = cv_q && slot_q == cur_q;
endmodule // csi_loop_model
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench for csi_edit
// Assumes: loop model supplies timing, bench drives APB and keys
// Notes: reads and step-up counts go through expectation queues
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   logic ctp, scp, ph2, lsp, fsp, lep, vdr, lfs, cloc;
   logic ins_key = 1'b0, hvalid = 1'b0, ce = 1'b0;
   logic su_key = 1'b0, shift = 1'b0;
   logic [7:0] hcode = 8'h00;
   logic dl, byp, erase, wr, clr, subusy, insbusy;
   logic p_ph = 1'b0, p_byp = 1'b0, p_ce = 1'b0, p_su = 1'b0;
   logic [7:0] xref = 8'hFF;
   logic [32:0] exp_q[$];
   int su_q[$];
   int fail_count = 0, check_count = 0, n_er = 0, n_wr = 0, r;
   integer seed = 32'h137F6767;
   always #5 clk = ~clk;
   csi_edit u_csi_edit (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CHAR_TIME_PULSE(ctp), .SECOND_CHAR_PHASE_PULSE(scp),
      .PHASE2_PULSE(ph2), .LINE_START_PULSE(lsp), .FRAME_START_PULSE(fsp),
      .LINE_END_PULSE(lep), .VDRIVE(vdr), .LINE_FIRST_SLOT(lfs),
      .CURSOR_LOCATED(cloc), .STEP_UP_KEY(su_key), .INSERT_KEY(ins_key),
      .SHIFT_KEY(shift), .HOST_CODE_VALID(hvalid), .HOST_CODE(hcode),
      .CE_SER_DATA(ce), .DL_SER_DATA(dl), .LOOP_BYPASS(byp),
      .CURSOR_ERASE(erase), .CURSOR_WRITE(wr), .COUNT88_CLEAR(clr),
      .STEP_UP_BUSY(subusy), .INSERT_BUSY(insbusy));
   csi_loop_model u_csi_loop_model (.clk(clk), .rst_n(rst_n),
      .cur_erase(erase), .cur_write(wr), .char_pulse(ctp), .phase_b(scp),
      .ph2(ph2), .line_start(lsp), .frame_start(fsp), .line_end(lep),
      .vdrive(vdr), .first_slot(lfs), .cur_loc(cloc));
   task automatic cmp_word(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t word got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_bit(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t bit got %b exp %b", $time, g, e);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wt(input int sel, input logic lvl, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         if (((sel == 0) ? subusy : byp) === lvl) break;
      end
      if (i >= n) begin
         fail_count++;
         $display("[ERR] %0t wait ran out", $time);
         final_report();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) wt(0, 1'bz, 0);
   endtask
   task automatic host(input logic [7:0] c);
      @(posedge clk);
      hvalid <= 1'b1;
      hcode <= c;
      @(posedge clk);
      hvalid <= 1'b0;
   endtask
   always @(posedge clk) begin
      r = $random(seed);
      ce <= r[0];
   end
   // monitor: reads, step-up pulse counts, bits into the delay line
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         cmp_word({pslverr, prdata}, exp_q.pop_front());
      if (!rst_n) begin
         n_er = 0;
         n_wr = 0;
      end
      if (erase === 1'b1) n_er++;
      if (wr === 1'b1) n_wr++;
      if (p_su && subusy === 1'b0 && su_q.size() > 0) begin
         cmp_word(33'(n_er), 33'(su_q[0]));
         cmp_word(33'(n_wr), 33'(su_q.pop_front()));
      end
      if (p_ph && p_byp) begin
         cmp_bit(dl, xref[0]);
         xref = {p_ce, xref[7:1]};
      end
      if (!p_byp) xref = csi_pkg::IDLE_CODE;
      p_ph = ph2;
      p_byp = byp;
      p_ce = ce;
      p_su = subusy;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, csi_pkg::ADDR_STATUS, 32'h0, 33'h0);
      apb(1'b0, csi_pkg::ADDR_COUNT, 32'h0, 33'h0);
      apb(1'b1, csi_pkg::ADDR_COUNT, 32'hFFFFFFFF, 33'h0);
      apb(1'b0, csi_pkg::ADDR_COUNT, 32'h0, 33'h0);
      apb(1'b0, 8'h0C, 32'h0, 33'h100000000);
      apb(1'b0, csi_pkg::ADDR_CTRL, 32'h0, 33'h0);
      su_q.push_back(int'(csi_pkg::LINES_TO_DECODE) + 1);
      apb(1'b1, csi_pkg::ADDR_CTRL, 32'h1, 33'h0);
      wt(0, 1'b1, 10);
      wt(0, 1'b0, 45000);
      host(csi_pkg::CODE_ESC);
      host(csi_pkg::CODE_DC3);
      repeat (4) @(posedge clk);
      #1 cmp_bit(subusy, 1'b0);
      host(csi_pkg::CODE_DC3);
      wt(0, 1'b1, 5);
      repeat (20) @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1 cmp_bit(subusy, 1'b0);
      cmp_bit(dl, 1'b1);
      cmp_bit(clr, 1'b1);
      @(posedge clk);
      rst_n <= 1'b1;
      su_key <= 1'b1;
      @(posedge clk);
      su_key <= 1'b0;
      ins_key <= 1'b1;
      shift <= 1'b1;
      @(posedge clk);
      ins_key <= 1'b0;
      shift <= 1'b0;
      #1 cmp_bit(subusy, 1'b1);
      repeat (2) @(posedge clk);
      #1 cmp_bit(insbusy, 1'b0);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, csi_pkg::ADDR_STATUS, 32'h0, 33'h0);
      @(posedge clk);
      ins_key <= 1'b1;
      @(posedge clk);
      ins_key <= 1'b0;
      wt(1, 1'b1, 22000);
      cmp_bit(clr, 1'b1);
      cmp_bit(insbusy, 1'b1);
      wt(1, 1'b0, 2000);
      repeat (3) @(posedge clk);
      #1 cmp_bit(insbusy, 1'b0);
      @(posedge clk);
      shift <= 1'b1;
      ins_key <= 1'b1;
      @(posedge clk);
      ins_key <= 1'b0;
      wt(1, 1'b1, 22000);
      cmp_bit(insbusy, 1'b1);
      repeat (8) @(posedge clk);
      #1 cmp_bit(clr, 1'b0);
      final_report();
   end
endmodule // tb
`default_nettype wire

// ---- src/csi_code_det.sv ----
// Purpose: spots a host step-up code that is not an escape sequence
// Assumes: CODE_VALID marks one received code per cycle
// Notes: escape memory spans exactly one code
`timescale 1ns/10ps
`default_nettype none
module csi_code_det (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic code_valid,
   input wire logic [7:0] code,
   output logic step_up_code
);
   logic esc_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         esc_q <= 1'b0;
      end else if (code_valid) begin
         esc_q <= (code == csi_pkg::CODE_ESC);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_up_code <= 1'b0;
      end else begin
         step_up_code <= code_valid && code == csi_pkg::CODE_DC3 && !esc_q;
      end
   end
endmodule // csi_code_det
`default_nettype wire

// ---- src/csi_count88.sv ----
// Purpose: 88-count counter with start, clear and one-cycle completion
// Assumes: tick is a one-cycle pulse
// Notes: done comes one cycle after the 88th tick
`timescale 1ns/10ps
`default_nettype none
module csi_count88 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic start,
   input wire logic tick,
   output logic en,
   output logic [6:0] count,
   output logic done
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en <= 1'b0;
         count <= 7'h00;
      end else if (clear) begin
         en <= 1'b0;
         count <= 7'h00;
      end else if (start) begin
         en <= 1'b1;
         count <= 7'h00;
      end else if (en && tick) begin
         if (count == csi_pkg::C88_LAST) begin
            en <= 1'b0;
            count <= 7'h00;
         end else begin
            count <= count + 7'h01;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else begin
         done <= !clear && !start && en && tick && count == csi_pkg::C88_LAST;
      end
   end
endmodule // csi_count88
`default_nettype wire

// ---- src/csi_edit.sv ----
// Purpose: cursor step-up and insert-character/line edit logic, APB slave
// Assumes: all timing inputs synchronous, pulse inputs one cycle wide, CURSOR_LOCATED a level, loop bit per PHASE2
// Notes: step-up and insert exclude each other unless both are requested in the same cycle; requests while busy drop
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module csi_edit (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CHAR_TIME_PULSE,
   input wire logic SECOND_CHAR_PHASE_PULSE,
   input wire logic PHASE2_PULSE,
   input wire logic LINE_START_PULSE,
   input wire logic FRAME_START_PULSE,
   input wire logic LINE_END_PULSE,
   input wire logic VDRIVE,
   input wire logic LINE_FIRST_SLOT,
   input wire logic CURSOR_LOCATED,
   input wire logic STEP_UP_KEY,
   input wire logic INSERT_KEY,
   input wire logic SHIFT_KEY,
   input wire logic HOST_CODE_VALID,
   input wire logic [7:0] HOST_CODE,
   input wire logic CE_SER_DATA,
   output logic DL_SER_DATA,
   output logic LOOP_BYPASS,
   output logic CURSOR_ERASE,
   output logic CURSOR_WRITE,
   output logic COUNT88_CLEAR,
   output logic STEP_UP_BUSY,
   output logic INSERT_BUSY
);
   csi_pkg::csi_su_e su_q;
   csi_pkg::csi_su_e su_d;
   csi_pkg::csi_status_s status;
   logic cur_q;
   logic loc_rise;
   logic host_step_up;
   logic su_req;
   logic ic_req;
   logic il_req;
   logic twelve_done_q;
   logic su_first_q;
   logic [7:0] xreg_q;
   logic ins_flag_q;
   logic ins_char_q;
   logic ins_line_q;
   logic line_en_q;
   logic line_latch;
   logic su_arming;
   logic su_counting;
   logic line_tick;
   logic c88_start;
   logic c88_tick;
   logic c88_clear;
   logic c88_en;
   logic c88_done;
   logic [6:0] c88_count;
   logic sw_wr;
   logic [31:0] rd_d;
   logic err_d;

   // register decode shared by read and write paths
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == csi_pkg::ADDR_CTRL) || (a == csi_pkg::ADDR_STATUS) ||
                (a == csi_pkg::ADDR_COUNT);
   endfunction

   csi_code_det u_code_det (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .code_valid(HOST_CODE_VALID),
      .code(HOST_CODE),
      .step_up_code(host_step_up)
   );

   csi_count88 u_count88 (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .clear(c88_clear),
      .start(c88_start),
      .tick(c88_tick),
      .en(c88_en),
      .count(c88_count),
      .done(c88_done)
   );

   // apb: zero wait, answer prepared during setup phase
   assign PREADY = 1'b1;
   assign sw_wr = PSEL && PENABLE && PWRITE &&
                  PADDR == csi_pkg::ADDR_CTRL;

   always_comb begin
      status = '0;
      status.su_state = su_q;
      status.twelve_done = twelve_done_q;
      status.su_first = su_first_q;
      status.su_second = (su_q == csi_pkg::SU_RUN) ||
                         (su_q == csi_pkg::SU_LAST_ARM);
      status.ins_flag = ins_flag_q;
      status.ins_char_req = ins_char_q;
      status.ins_line_req = ins_line_q;
      status.line_en = line_en_q;
      status.c88_en = c88_en;
   end

   always_comb begin
      rd_d = 32'h00000000;
      err_d = !addr_ok(PADDR);
      case (PADDR)
         csi_pkg::ADDR_STATUS: begin
            rd_d = status;
         end
         csi_pkg::ADDR_COUNT: begin
            rd_d = {17'h00000, c88_count, ~xreg_q};
         end
         default: begin
            rd_d = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PRDATA <= PWRITE ? 32'h00000000 : rd_d;
         PSLVERR <= err_d;
      end
   end

   // request sources: keys, host code, software strobes
   assign su_req = STEP_UP_KEY || host_step_up ||
                   (sw_wr && PWDATA[csi_pkg::CTRL_STEP_UP]);
   assign ic_req = (INSERT_KEY && !SHIFT_KEY) ||
                   (sw_wr && PWDATA[csi_pkg::CTRL_INS_CHAR]);
   assign il_req = (INSERT_KEY && SHIFT_KEY) ||
                   (sw_wr && PWDATA[csi_pkg::CTRL_INS_LINE]);

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cur_q <= 1'b0;
      end else begin
         cur_q <= CURSOR_LOCATED;
      end
   end
   assign loc_rise = CURSOR_LOCATED && !cur_q;

   // step-up sequencer
   always_comb begin
      su_d = su_q;
      case (su_q)
         csi_pkg::SU_IDLE: begin
            if (su_req && !INSERT_BUSY) begin
               su_d = csi_pkg::SU_ARM;
            end
         end
         csi_pkg::SU_ARM: begin
            if (loc_rise) begin
               su_d = csi_pkg::SU_RUN;
            end
         end
         csi_pkg::SU_RUN: begin
            if (c88_done) begin
               su_d = twelve_done_q ? csi_pkg::SU_LAST_ARM
                                    : csi_pkg::SU_REARM;
            end
         end
         csi_pkg::SU_REARM: begin
            if (loc_rise) begin
               su_d = twelve_done_q ? csi_pkg::SU_LAST_RUN
                                    : csi_pkg::SU_RUN;
            end
         end
         csi_pkg::SU_LAST_ARM: begin
            if (loc_rise) begin
               su_d = csi_pkg::SU_LAST_RUN;
            end
         end
         csi_pkg::SU_LAST_RUN: begin
            if (c88_done) begin
               su_d = csi_pkg::SU_IDLE;
            end
         end
         default: begin
            su_d = csi_pkg::SU_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         su_q <= csi_pkg::SU_IDLE;
      end else begin
         su_q <= su_d;
      end
   end

   assign su_arming = (su_q == csi_pkg::SU_ARM) ||
                      (su_q == csi_pkg::SU_REARM) ||
                      (su_q == csi_pkg::SU_LAST_ARM);
   assign su_counting = (su_q == csi_pkg::SU_RUN) ||
                        (su_q == csi_pkg::SU_REARM);
   assign STEP_UP_BUSY = (su_q != csi_pkg::SU_IDLE);

   // first step-up flag: set by request, idled by twelve-line decode
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         su_first_q <= 1'b0;
      end else if (su_q == csi_pkg::SU_IDLE) begin
         su_first_q <= su_req && !INSERT_BUSY;
      end else if (twelve_done_q) begin
         su_first_q <= 1'b0;
      end
   end

   localparam logic [3:0] LINES_LAST = csi_pkg::LINES_TO_DECODE - 4'h1;

   // twelve-line decode latch
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         twelve_done_q <= 1'b0;
      end else if (su_q == csi_pkg::SU_IDLE) begin
         twelve_done_q <= 1'b0;
      end else if (su_counting && LINE_START_PULSE &&
                   ~xreg_q == {4'h0, LINES_LAST}) begin
         twelve_done_q <= 1'b1;
      end
   end

   // extra register: insert data path, else twelve-line counter
   // count is kept inverted so that the rest value is the idle code
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         xreg_q <= csi_pkg::IDLE_CODE;
      end else if (ins_flag_q) begin
         if (PHASE2_PULSE) begin
            xreg_q <= {CE_SER_DATA, xreg_q[7:1]};
         end
      end else if (su_counting && !twelve_done_q) begin
         if (LINE_START_PULSE) begin
            xreg_q <= xreg_q - 8'h01;
         end
      end else if (su_q == csi_pkg::SU_IDLE || su_q == csi_pkg::SU_ARM) begin
         if (PHASE2_PULSE) begin
            xreg_q <= csi_pkg::IDLE_CODE;
         end
      end
   end

   // insert requests
   assign INSERT_BUSY = ins_char_q || ins_line_q;
   assign line_latch = ins_line_q && !line_en_q && SECOND_CHAR_PHASE_PULSE &&
                       CURSOR_LOCATED && LINE_FIRST_SLOT;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ins_char_q <= 1'b0;
      end else if (ins_char_q && ins_flag_q && LINE_END_PULSE) begin
         ins_char_q <= 1'b0;
      end else if (ic_req && !INSERT_BUSY && !STEP_UP_BUSY) begin
         ins_char_q <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ins_line_q <= 1'b0;
      end else if (ins_line_q && line_en_q && c88_done) begin
         ins_line_q <= 1'b0;
      end else if (il_req && !INSERT_BUSY && !STEP_UP_BUSY) begin
         ins_line_q <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         line_en_q <= 1'b0;
      end else if (!ins_line_q || c88_done) begin
         line_en_q <= 1'b0;
      end else if (line_latch) begin
         line_en_q <= 1'b1;
      end
   end

   // insert flag: splices the extra register into the loop
   assign line_tick = LINE_END_PULSE && (ins_line_q ? VDRIVE : 1'b1);
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ins_flag_q <= 1'b0;
      end else if (ins_flag_q) begin
         if (line_tick) begin
            ins_flag_q <= 1'b0;
         end
      // first insert-line frame: enable latches later in the same slot
      end else if (loc_rise && (ins_char_q || line_en_q || line_latch ||
                   (ins_line_q && LINE_FIRST_SLOT))) begin
         ins_flag_q <= 1'b1;
      end
   end
   assign LOOP_BYPASS = ins_flag_q;

   // delay-line input bit
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         DL_SER_DATA <= 1'b1;
      end else if (PHASE2_PULSE) begin
         DL_SER_DATA <= ins_flag_q ? xreg_q[0] : CE_SER_DATA;
      end
   end

   // 88-count control
   assign c88_start = (su_arming && loc_rise) || line_latch;
   assign c88_tick = line_en_q ? FRAME_START_PULSE : CHAR_TIME_PULSE;
   assign c88_clear = !(STEP_UP_BUSY || line_en_q || line_latch);
   assign COUNT88_CLEAR = c88_clear;

   // cursor erase at each located edge while step-up arms, rewrite at each step-up completion
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CURSOR_ERASE <= 1'b0;
         CURSOR_WRITE <= 1'b0;
      end else begin
         CURSOR_ERASE <= su_arming && loc_rise;
         CURSOR_WRITE <= c88_done && (su_q == csi_pkg::SU_RUN ||
                         su_q == csi_pkg::SU_LAST_RUN);
      end
   end

endmodule // csi_edit
`default_nettype wire

// ---- src/csi_pkg.sv ----
// Purpose: constants and types of the cursor step-up and insert edit block
// Assumes: all timing pulses are one CORE_CLK cycle wide
// Notes: Functional notes below
// Functional notes
// - step-up makes the cursor reappear in the exit register 14.872 ms later
// - step-up delay is one frame time less one 88-character line
// - step-up uses a twelve-line counter and an 88-character counter
// - 88 count starts at cursor; cursor written at end, erased at next start
// - idle step-up lets phase-two pulses hold the line counter at zero
// - step-up requested by key or host DC3 not directly after ESC
// - first cursor locate erases cursor, starts both counters at once
// - after 88 character times reinsert cursor; completion clears second flag
// - next cursor locate sets second flag again and restarts 88 count
// - cycle repeats until twelve-line decode idles the first flag
// - completion after the decode arrives later and its clear is ignored
// - next cursor edge runs thirteenth count; its completion ends step-up
// - insert-character puts all-ones Idle at cursor, shifts line right
// - cursor to line end delayed one character via extra 8-bit register
// - last line character held in extra register in retrace and dropped
// - insert key without shift: no line enable, 88 counter held clear
// - at cursor locate set insert flag, feed extra register, block loop
// - while inserting, extra register output feeds the delay line
// - line end pulse clears insert flag and restores normal loop path
// - insert key with shift performs insert-character 88 times
// - line enable latches on second phase pulse only at line-start slot
// - in insert-line, line end with vertical drive clears insert flag
// - insert-line ends after 88 frame pulses, counter cleared, idle
// - extra register rests at all ones: line zero count and Idle code
package csi_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CHAR_TIME_NS = 13000;
   localparam int unsigned FRAME_TIME_US = 16016;
   localparam int unsigned LINE_TIME_US = 1144;
   localparam int unsigned STEP_UP_DELAY_US = FRAME_TIME_US - LINE_TIME_US;
   localparam int unsigned CHAR_TIME_CYC = CHAR_TIME_NS / CLK_PERIOD_NS;
   localparam logic [6:0] CHARS_PER_LINE = 7'h58;
   localparam logic [6:0] C88_LAST = 7'h57;
   localparam logic [3:0] LINES_TO_DECODE = 4'hC;
   localparam logic [7:0] IDLE_CODE = 8'hFF;
   localparam logic [7:0] CODE_DC3 = 8'h13;
   localparam logic [7:0] CODE_ESC = 8'h1B;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam int unsigned CTRL_STEP_UP = 0;
   localparam int unsigned CTRL_INS_CHAR = 1;
   localparam int unsigned CTRL_INS_LINE = 2;
   typedef enum logic [2:0] {
      SU_IDLE = 3'b000,
      SU_ARM = 3'b001,
      SU_RUN = 3'b010,
      SU_REARM = 3'b011,
      SU_LAST_ARM = 3'b100,
      SU_LAST_RUN = 3'b101
   } csi_su_e;
   typedef struct packed {
      logic [20:0] zero;
      logic [2:0] su_state;
      logic twelve_done;
      logic su_first;
      logic su_second;
      logic ins_flag;
      logic ins_char_req;
      logic ins_line_req;
      logic line_en;
      logic c88_en;
   } csi_status_s;
endpackage
